// [common/rsr_pkg.sv]
// constants and carrier types for the reset and stop recovery controller
// assumes a 25 MHz ref_clk standing in for the precision oscillator
package rsr_pkg;
  localparam int RSR_SHORT_HOLD = 66;
  localparam int RSR_LONG_HOLD = 5000;
  localparam int RSR_PIN_MIN_CLKS = 4;
  localparam int RSR_CLK_MHZ = 25;
  localparam int RSR_STOP_GLITCH_NS = 12;
  // shortest stop-mode pulse in cycles, rounded up, at least one
  localparam int RSR_STOP_GLITCH_CLKS_RAW =
    (RSR_STOP_GLITCH_NS * RSR_CLK_MHZ + 999) / 1000;
  localparam int RSR_STOP_GLITCH_CLKS =
    (RSR_STOP_GLITCH_CLKS_RAW < 1) ? 1 : RSR_STOP_GLITCH_CLKS_RAW;
  localparam int RSR_CNT_W = 13;
  localparam logic [15:0] RSR_RESET_VEC_HI_ADDR = 16'h0002;
  localparam logic [15:0] RSR_RESET_VEC_LO_ADDR = 16'h0003;
  // bus offsets, byte addresses of aligned words
  localparam logic [3:0] RSR_OFS_STATUS = 4'h0;
  localparam logic [3:0] RSR_OFS_CTRL = 4'h4;
  localparam logic [3:0] RSR_OFS_GPIO_EN = 4'h8;
  localparam int RSR_ST_POR = 7;
  localparam int RSR_ST_STOP = 6;
  localparam int RSR_ST_WDT = 5;
  localparam int RSR_ST_EXT = 4;
  localparam int RSR_CTRL_DBG_RST = 0;
  localparam int RSR_CTRL_STOP_REQ = 1;
  localparam logic [7:0] RSR_STATUS_RST = 8'h80;
  typedef struct packed {
    logic xtal_enable;
    logic watchdog_action_option;
    logic brownout_always_on_option;
  } rsr_opt_t;
  typedef struct packed {
    logic cpu_reset;
    logic periph_reset;
    logic ctl_reset;
    logic wdt_oscillator_control_reg_reset;
    logic gpio_reset;
    logic osc_select_ipo;
    logic vector_fetch;
  } rsr_rst_out_t;
  typedef enum logic [1:0] {
    RSR_IDLE,
    RSR_WAIT_SUPPLY,
    RSR_HOLD,
    RSR_WAIT_PIN
  } rsr_state_t;
endpackage

// [src/rsr_ctrl.sv]
// reset and stop-mode recovery sequencer with avalon-mm status access
// assumes supply monitors and option bits are synchronous to ref_clk
`timescale 1ns/1ps
// Notes on behaviour
// - five sources start a system reset
// - in stop, watchdog or gpio change recovers
// - hold 66 cycles without crystal
// - hold 5000 cycles with crystal enabled
// - recovery resets cpu, watchdog, oscillator control only
// - supply resets count after supply good
// - held pin extends reset until release
// - gpio reset to inputs, pull-ups off
// - shared pin drives low during reset; here only in system reset supply wait and hold, not in pin wait or recovery
// - cpu, peripherals idle; oscillators keep running
// - control registers load reset values
// - cpu fetches vector from 0002h and 0003h
// - system reset selects precision oscillator
// - normal pin pulses under four clocks ignored
// - stop pin pulses under 12 ns ignored
// - debugger reset spares debugger block
// - power-on counter starts after supply good
// - power-on sets por cause bit
// - brownout holds reset then full power-on
// - brownout monitor in stop follows option
// - watchdog resets if option 1, else interrupts
// - watchdog reset sets watchdog cause bit
// - pin reset sets external cause bit
// - status read clears upper four bits
// - debug pin in stop gives system reset
// - stop recovery sets stop cause bit
module rsr_ctrl import rsr_pkg::*; #(
  parameter int GPIO_W = 8,
  parameter int LONG_HOLD = RSR_LONG_HOLD
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic power_on_detect,
  input wire logic supply_above_por,
  input wire logic brownout_detect,
  input wire logic watchdog_timeout,
  input wire logic reset_pin_in,
  input wire logic pin_reset_enable,
  input wire logic debug_pin_reset,
  input wire logic [GPIO_W-1:0] gpio_in,
  input wire rsr_opt_t opt,
  output logic reset_pin_out,
  output logic reset_pin_oe_b,
  output rsr_rst_out_t rst_out,
  output logic brownout_monitor_en,
  output logic watchdog_irq,
  output logic in_stop,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  rsr_state_t state_r;
  logic [RSR_CNT_W-1:0] cnt_r;
  logic is_sys_r;
  logic pin_s1_r, pin_s2_r;
  logic [2:0] pin_low_r;
  logic [GPIO_W-1:0] gpio_prev_r, gpio_en_r;
  logic [7:0] status_r;
  logic dbg_rst_r, stop_r, ack_r;
  logic pin_low, pin_req, sys_req, smr_req, supply_req, gpio_chg;
  logic [1:0] quiet_r;
  logic ext_low;
  logic wait_done;
  logic [RSR_CNT_W-1:0] hold_cnt;
  logic [3:0] pin_min;
  logic bus_req;

  // two-flop pin synchroniser
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
    end else begin
      pin_s1_r <= reset_pin_in;
      pin_s2_r <= pin_s1_r;
    end
  end
  assign pin_low = !pin_s2_r;

  // own drive echoes through the synchroniser; trust the pin when quiet
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      quiet_r <= 2'h0;
    end else if (!reset_pin_oe_b) begin
      quiet_r <= 2'h0;
    end else if (quiet_r != 2'h3) begin
      quiet_r <= quiet_r + 2'h1;
    end
  end
  assign ext_low = pin_low && (quiet_r == 2'h3);
  assign wait_done = (quiet_r == 2'h3) && !(ext_low && pin_reset_enable);

  // pulse width qualification, stop mode uses its own short width
  assign pin_min = stop_r ? 4'(RSR_STOP_GLITCH_CLKS) : 4'(RSR_PIN_MIN_CLKS);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_low_r <= 3'h0;
    end else if (!ext_low || !pin_reset_enable) begin
      pin_low_r <= 3'h0;
    end else if (pin_low_r != 3'h7) begin
      pin_low_r <= pin_low_r + 3'h1;
    end
  end
  assign pin_req = pin_reset_enable && ext_low
    && ({1'b0, pin_low_r} + 4'h1 >= pin_min);

  assign supply_req = power_on_detect || brownout_detect;
  // in stop the debug pin stands for the debugger's own request
  assign sys_req = supply_req || pin_req || dbg_rst_r
    || (watchdog_timeout && opt.watchdog_action_option && !stop_r)
    || (stop_r && debug_pin_reset);
  assign gpio_chg = |((gpio_in ^ gpio_prev_r) & gpio_en_r);
  assign smr_req = stop_r && (watchdog_timeout || gpio_chg);
  assign hold_cnt = opt.xtal_enable ?
    RSR_CNT_W'(LONG_HOLD - 1) : RSR_CNT_W'(RSR_SHORT_HOLD - 1);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      gpio_prev_r <= '0;
    end else begin
      gpio_prev_r <= gpio_in;
    end
  end

  // sequencer
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= RSR_WAIT_SUPPLY;
      cnt_r <= '0;
      is_sys_r <= 1'b1;
    end else begin
      case (state_r)
        RSR_IDLE: begin
          if (sys_req) begin
            is_sys_r <= 1'b1;
            state_r <= RSR_WAIT_SUPPLY;
          end else if (smr_req) begin
            is_sys_r <= 1'b0;
            cnt_r <= hold_cnt;
            state_r <= RSR_HOLD;
          end
        end
        RSR_WAIT_SUPPLY: begin
          cnt_r <= hold_cnt;
          if (supply_above_por && !supply_req) begin
            state_r <= RSR_HOLD;
          end
        end
        RSR_HOLD: begin
          if (supply_req) begin
            state_r <= RSR_WAIT_SUPPLY;
          end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - RSR_CNT_W'(1);
          end else begin
            state_r <= RSR_WAIT_PIN;
          end
        end
        RSR_WAIT_PIN: begin
          if (supply_req) begin
            state_r <= RSR_WAIT_SUPPLY;
          end else if (wait_done) begin
            state_r <= RSR_IDLE;
          end
        end
        default: state_r <= RSR_WAIT_SUPPLY;
      endcase
    end
  end

  // stop mode entry and exit
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stop_r <= 1'b0;
    end else if (state_r != RSR_IDLE || sys_req || smr_req) begin
      stop_r <= 1'b0;
    end else if (avs_write && ack_r && avs_address == RSR_OFS_CTRL) begin
      stop_r <= avs_writedata[RSR_CTRL_STOP_REQ];
    end
  end

  // debugger reset bit clears itself during the reset it starts
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dbg_rst_r <= 1'b0;
    end else if (state_r != RSR_IDLE) begin
      dbg_rst_r <= 1'b0;
    end else if (avs_write && ack_r && avs_address == RSR_OFS_CTRL) begin
      dbg_rst_r <= avs_writedata[RSR_CTRL_DBG_RST];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      gpio_en_r <= '0;
    end else if (avs_write && ack_r && avs_address == RSR_OFS_GPIO_EN) begin
      gpio_en_r <= avs_writedata[GPIO_W-1:0];
    end
  end

  // cause bits; a set in the read cycle wins over the clear
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_r <= RSR_STATUS_RST;
    end else if (state_r == RSR_IDLE && sys_req) begin
      status_r <= 8'h00;
      status_r[RSR_ST_POR] <= supply_req || dbg_rst_r
        || (stop_r && debug_pin_reset);
      status_r[RSR_ST_WDT] <= watchdog_timeout
        && opt.watchdog_action_option;
      status_r[RSR_ST_EXT] <= pin_req;
    end else if (state_r == RSR_IDLE && smr_req) begin
      status_r <= 8'h00;
      status_r[RSR_ST_STOP] <= 1'b1;
      status_r[RSR_ST_WDT] <= watchdog_timeout;
    end else if (avs_read && ack_r && avs_address == RSR_OFS_STATUS) begin
      status_r[7:4] <= 4'h0;
    end
  end

  // reset outputs
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_out <= '1;
      reset_pin_out <= 1'b0;
      reset_pin_oe_b <= 1'b0;
      watchdog_irq <= 1'b0;
      brownout_monitor_en <= 1'b1;
      in_stop <= 1'b0;
    end else begin
      rst_out.cpu_reset <= state_r != RSR_IDLE;
      rst_out.periph_reset <= state_r != RSR_IDLE && is_sys_r;
      rst_out.ctl_reset <= state_r != RSR_IDLE && is_sys_r;
      rst_out.wdt_oscillator_control_reg_reset <= state_r != RSR_IDLE;
      rst_out.gpio_reset <= state_r != RSR_IDLE && is_sys_r;
      rst_out.osc_select_ipo <= state_r != RSR_IDLE;
      // one-cycle pulse: cpu loads pc from the vector words
      rst_out.vector_fetch <= state_r == RSR_WAIT_PIN
        && wait_done && !supply_req;
      reset_pin_out <= 1'b0;
      // released while waiting on the pin so an outside pull can be seen
      reset_pin_oe_b <= !((state_r == RSR_WAIT_SUPPLY
        || state_r == RSR_HOLD) && is_sys_r);
      watchdog_irq <= watchdog_timeout && !opt.watchdog_action_option;
      brownout_monitor_en <= !stop_r || opt.brownout_always_on_option;
      in_stop <= stop_r;
    end
  end

  // avalon slave: one wait cycle, then acknowledge
  assign bus_req = (avs_read || avs_write) && !ack_r;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_r <= bus_req;
      avs_readdata <= 32'h0000_0000;
      if (bus_req && avs_read) begin
        case (avs_address)
          RSR_OFS_STATUS: avs_readdata <= {24'h00_0000, status_r};
          RSR_OFS_CTRL: avs_readdata <= {30'h0, stop_r, dbg_rst_r};
          RSR_OFS_GPIO_EN: avs_readdata <= 32'(gpio_en_r);
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign avs_waitrequest = !ack_r;
endmodule // rsr_ctrl

// [test/rsr_partner.sv]
// far side model: supply monitors and the external reset pin
// assumes the bench asks for brownout dips and pin pulls
`timescale 1ns/1ps
module rsr_partner (
  input wire logic ref_clk,
  input wire logic sag,
  input wire logic pull_low,
  input wire logic reset_pin_oe_b,
  output logic power_on_detect,
  output logic supply_above_por,
  output logic brownout_detect,
  output logic reset_pin_in
);
  int t = 30;
  logic up_r = 1'b0;
  always @(posedge ref_clk) begin
    if (sag && up_r) t <= 12;
    else if (t > 0) t <= t - 1;
    if (t == 0) up_r <= 1'b1;
  end
  // supply rises late; after a dip it stays low past the brownout
  assign supply_above_por = (t == 0);
  assign power_on_detect = !up_r;
  assign brownout_detect = up_r && t > 4;
  // open-drain wire with pull-up
  assign reset_pin_in = !(pull_low || !reset_pin_oe_b);
endmodule // rsr_partner

// [test/rsr_ctrl_checker.sv]
// port checks on the reset sequencer
// assumes binding onto rsr_ctrl, one clock, async active-low reset
`timescale 1ns/1ps
module rsr_ctrl_checker import rsr_pkg::*; #(
  parameter int LONG_HOLD = RSR_LONG_HOLD
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic supply_above_por,
  input wire logic brownout_detect,
  input wire logic watchdog_timeout,
  input wire rsr_opt_t opt,
  input wire logic reset_pin_oe_b,
  input wire rsr_rst_out_t rst_out,
  input wire logic brownout_monitor_en,
  input wire logic watchdog_irq,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [12:0] run_r;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) run_r <= 13'h0;
    else if (rst_out.cpu_reset) run_r <= run_r + 13'h1;
    else run_r <= 13'h0;
  end
  sequence release_s;
    $fell(rst_out.cpu_reset);
  endsequence
  sequence supply_low_s;
    !supply_above_por [*3];
  endsequence
  hold_len_a:
    assert property (release_s |->
      run_r >= (opt.xtal_enable ? LONG_HOLD : RSR_SHORT_HOLD))
    else $error("reset hold too short");
  supply_hold_a:
    assert property (supply_low_s |=> rst_out.cpu_reset)
    else $error("released while supply low");
  brownout_rst_a:
    assert property (brownout_detect && brownout_monitor_en |->
      ##2 rst_out.cpu_reset) else $error("brownout ignored");
  wdt_reset_a:
    assert property (watchdog_timeout && opt.watchdog_action_option |->
      ##2 rst_out.cpu_reset) else $error("watchdog reset missing");
  wdt_irq_a:
    assert property (watchdog_irq ==
      $past(watchdog_timeout && !opt.watchdog_action_option))
    else $error("watchdog interrupt wrong");
  pin_drive_a:
    assert property (!reset_pin_oe_b |-> rst_out.cpu_reset &&
      rst_out.ctl_reset) else $error("pin driven outside reset");
  vec_fetch_a:
    assert property (release_s |-> $past(rst_out.vector_fetch))
    else $error("no vector fetch at release");
  bus_answer_a:
    assert property ((avs_read || avs_write) && avs_waitrequest |=>
      !avs_waitrequest) else $error("bus answer late");
endmodule // rsr_ctrl_checker
bind rsr_ctrl rsr_ctrl_checker #(.LONG_HOLD(LONG_HOLD)) u_chk (
  .ref_clk, .rst_b, .supply_above_por, .brownout_detect,
  .watchdog_timeout, .opt, .reset_pin_oe_b, .rst_out,
  .brownout_monitor_en, .watchdog_irq, .avs_read, .avs_write,
  .avs_waitrequest);

// [test/rsr_ctrl_bench.sv]
// self-checking bench for the reset sequencer
// assumes rsr_partner drives the pin and supply levels
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin \
  miscompares++; $display("CHECK FAILED %s exp %0h got %0h", n, e, s); \
  end end
module rsr_ctrl_bench;
  import rsr_pkg::*;
  localparam logic [5:0] SYS = 6'b111110;
  localparam logic [5:0] STP = 6'b101011;
  logic ref_clk = 1'b0, rst_b = 1'b0, sag = 1'b0, pull_low = 1'b0;
  logic watchdog_timeout = 1'b0, pin_reset_enable = 1'b1;
  logic debug_pin_reset = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0] gpio_in = 8'h00, m;
  rsr_opt_t opt = 3'b010;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic power_on_detect, supply_above_por, brownout_detect, reset_pin_in;
  logic reset_pin_out, reset_pin_oe_b, brownout_monitor_en;
  logic watchdog_irq, in_stop, avs_waitrequest;
  rsr_rst_out_t rst_out;
  logic [5:0] snap;
  logic [5:0] es_t [4] = '{STP, STP, SYS, SYS};
  logic [7:0] st_t [4] = '{8'h40, 8'h60, 8'h80, 8'h10};
  int checked = 0, miscompares = 0, n, k;
  always #20 ref_clk = ~ref_clk;
  rsr_partner u_far (.ref_clk, .sag, .pull_low, .reset_pin_oe_b,
    .power_on_detect, .supply_above_por, .brownout_detect, .reset_pin_in);
  rsr_ctrl #(.GPIO_W(8), .LONG_HOLD(200)) u_dut (.ref_clk, .rst_b,
    .power_on_detect, .supply_above_por, .brownout_detect,
    .watchdog_timeout, .reset_pin_in, .pin_reset_enable, .debug_pin_reset,
    .gpio_in, .opt, .reset_pin_out, .reset_pin_oe_b, .rst_out,
    .brownout_monitor_en, .watchdog_irq, .in_stop, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest);
  task automatic final_report;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tk(input int c);
    repeat (c) @(posedge ref_clk);
  endtask
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int i;
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    i = 0;
    do begin
      tk(1);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 40);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (i >= 40) begin
      miscompares++;
      final_report;
    end
    tk(1);
  endtask
  task automatic pulse(input int w);
    pull_low <= 1'b1;
    tk(w);
    pull_low <= 1'b0;
  endtask
  task automatic wd;
    watchdog_timeout <= 1'b1;
    tk(1);
    watchdog_timeout <= 1'b0;
  endtask
  task automatic hold(input int lim, input logic [5:0] es,
                      input logic [7:0] st);
    int i;
    i = 0;
    while (rst_out.cpu_reset !== 1'b1 && i < 12) begin
      tk(1);
      i++;
    end
    n = 0;
    while (rst_out.cpu_reset === 1'b1 && n < 9000) begin
      tk(1);
      n++;
      if (n == 40) snap = {rst_out.cpu_reset, rst_out.ctl_reset,
        rst_out.wdt_oscillator_control_reg_reset, rst_out.gpio_reset,
        rst_out.osc_select_ipo, reset_pin_oe_b};
    end
    if (i >= 12 || n >= 9000) begin
      miscompares++;
      final_report;
    end
    `CHK("hold", 1'b1, n >= lim)
    `CHK("kind", es, snap)
    bus(1'b0, RSR_OFS_STATUS, 32'h0);
    `CHK("cause", st, q[7:0])
    bus(1'b0, RSR_OFS_STATUS, 32'h0);
    `CHK("cleared", 8'h00, q[7:0])
    $display("test done, hold %0d cycles", n);
  endtask
  initial begin
    k = $urandom(51865);
    tk(4);
    rst_b <= 1'b1;
    hold(90, SYS, 8'h80);
    pulse(3);
    tk(12);
    `CHK("short pin", 1'b0, rst_out.cpu_reset)
    pin_reset_enable <= 1'b0;
    pulse(8);
    tk(12);
    `CHK("pin off", 1'b0, rst_out.cpu_reset)
    pin_reset_enable <= 1'b1;
    pulse(4 + $urandom % 6);
    hold(60, SYS, 8'h10);
    fork
      pulse(150);
      hold(140, SYS, 8'h10);
    join
    wd;
    hold(66, SYS, 8'h20);
    opt.watchdog_action_option <= 1'b0;
    wd;
    tk(12);
    `CHK("wdt irq only", 1'b0, rst_out.cpu_reset)
    opt <= 3'b110;
    wd;
    hold(200, SYS, 8'h20);
    opt.xtal_enable <= 1'b0;
    bus(1'b1, RSR_OFS_CTRL, 32'h1);
    hold(60, SYS, 8'h80);
    sag <= 1'b1;
    tk(1);
    sag <= 1'b0;
    hold(70, SYS, 8'h80);
    m = ($urandom & 8'hfe) | 8'h02;
    bus(1'b1, RSR_OFS_GPIO_EN, {24'h0, m});
    for (k = 0; k < 4; k++) begin
      opt.brownout_always_on_option <= k[0];
      bus(1'b1, RSR_OFS_CTRL, 32'h2);
      tk(2);
      `CHK("stop", 1'b1, in_stop)
      `CHK("bo mon", k[0], brownout_monitor_en)
      case (k)
        0: begin
          gpio_in[0] <= ~gpio_in[0];
          tk(8);
          `CHK("masked gpio", 1'b1, in_stop)
          gpio_in[1] <= ~gpio_in[1];
        end
        1: wd;
        2: begin
          debug_pin_reset <= 1'b1;
          tk(1);
          debug_pin_reset <= 1'b0;
        end
        default: pulse(1);
      endcase
      hold(60, es_t[k], st_t[k]);
    end
    bus(1'b1, 4'hc, 32'hffff_ffff);
    bus(1'b0, 4'hc, 32'h0);
    `CHK("unmapped", 32'h0, q)
    final_report;
  end
endmodule // rsr_ctrl_bench
